// ==== inc/ite_pkg.sv ====
/*
 * ite_pkg: shared constants of the i2c target engine.
 * assumes: used only as ite_pkg::name, never imported.
 */
package ite_pkg;
	localparam logic [1:0] MODE_I2C      = 2'h3;       // mode select code for i2c operation
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;      // general call address byte
	localparam logic [4:0] TEN_PREFIX    = 5'h1e;      // 11110b lead of a 10-bit first byte
	localparam logic [1:0] ASTP_BYTECNT  = 2'h2;       // auto stop driven by byte count
	localparam int         DATA_W        = 8;          // one i2c byte
	localparam int         FIFO_DEPTH    = 16;         // transmit buffering words
	localparam int         OA_W          = 10;         // own address width
	localparam int         BRW_W         = 16;         // bit-rate divider width
	localparam int         BCNT_W        = 8;          // byte count threshold width
	localparam logic [3:0] BIT_LAST      = 4'h7;       // index of the last bit of a byte
	localparam logic [3:0] BIT_DONE      = 4'h8;       // all eight bits sampled

	// gray codes along receive and transmit paths
	typedef enum logic [3:0] {
		ITE_IDLE    = 4'h0,
		ITE_ADDR    = 4'h1,
		ITE_ACK     = 4'h3,
		ITE_RX      = 4'h2,
		ITE_RX_HOLD = 4'h6,
		ITE_TX      = 4'h7,
		ITE_TX_ACK  = 4'h5,
		ITE_WAIT_TX = 4'h4,
		ITE_IGNORE  = 4'hc
	} ite_state_t;
endpackage

// ==== hdl/ite_top.sv ====
/*
 * ite_fifo and ite_top: i2c target engine with a transmit fifo.
 * assumes: scl/sda are open-drain pins resolved outside from the *_oe
 * outputs; all control inputs come from logic on sys_clk.
 */
// Functional notes
// RL1 - target only in i2c sync non-master mode
// RL2 - direction starts cleared, then follows R/W
// RL3 - match own address, 7 or 10 bit
// RL4 - general call only when enabled
// RL5 - after start, match address, flag start
// RL6 - read match: transmit, msb first on sda
// RL7 - read: direction, tx request, stretch, ack
// RL8 - tx request on every buffer to shifter
// RL9 - after master ack, next byte or stretch
// RL10 - tx nack+stop flags stop, restart readdresses
// RL11 - write match: receive, flag, auto ack
// RL12 - unread byte stretches scl until read
// RL13 - send nack bit nacks next ack cycle
// RL14 - nack while stretched: release, overwrite buffer
// RL15 - rx stop flags stop, restart readdresses
// RL16 - 10-bit full address: receive, start flag
// RL17 - 10-bit restart read: start flag, transmit
// RL18 - software configures only under software reset
// RL19 - bit rate is clock over divider
// RL20 - byte count threshold with auto stop
// RL21 - request per byte received or asked
// RL22 - software reset stops, releases, clears flags
// RL23 - busy set on start, cleared on stop
// RL24 - 10-bit first byte prefix, top bits
// RL25 - no match: no ack, ignore till start
`timescale 1ns/1ps

module ite_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// honest full/empty from the occupancy count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage, written only on accepted pushes
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count; flush drops everything held
	always_ff @(posedge sys_clk) begin
		if (rst || flush) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // ite_fifo

module ite_top #(
	parameter int TX_DEPTH = ite_pkg::FIFO_DEPTH
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        scl_i,
	output logic                             scl_o,
	output logic                             scl_oe,
	input  wire logic                        sda_i,
	output logic                             sda_o,
	output logic                             sda_oe,
	input  wire logic                        software_reset_bit,
	input  wire logic [1:0]                  mode_select_field,
	input  wire logic                        sync_mode_bit,
	input  wire logic                        master_select_bit,
	input  wire logic [ite_pkg::OA_W-1:0]    own_address_reg0,
	input  wire logic                        own_address_width_bit,
	input  wire logic                        general_call_enable,
	input  wire logic                        send_nack_bit,
	input  wire logic [ite_pkg::BRW_W-1:0]   bit_rate_divider,
	input  wire logic [ite_pkg::BCNT_W-1:0]  byte_count_threshold,
	input  wire logic [1:0]                  auto_stop_field,
	input  wire logic [ite_pkg::DATA_W-1:0]  transmit_buffer,
	input  wire logic                        tx_valid,
	output logic                             tx_ready,
	output logic      [ite_pkg::DATA_W-1:0]  receive_buffer,
	input  wire logic                        receive_read,
	input  wire logic                        start_clear,
	input  wire logic                        stop_clear,
	input  wire logic                        tx_request_clear,
	output logic                             start_detect_flag,
	output logic                             stop_detect_flag,
	output logic                             transmit_request_flag,
	output logic                             receive_flag,
	output logic                             bus_busy_flag,
	output logic                             transfer_direction_bit,
	output logic                             bit_rate_tick,
	output logic                             byte_count_hit
);
	ite_pkg::ite_state_t             st_q;
	ite_pkg::ite_state_t             next_q;
	logic [3:0]                      cnt_q;
	logic [ite_pkg::DATA_W-1:0]      sr_q;
	logic                            ack_low_q;
	logic                            wait_addr_q;
	logic                            second_q;
	logic                            ten_ok_q;
	logic                            active_q;
	logic                            set_start_q;
	logic                            set_rx_q;
	logic                            nack_used_q;
	logic                            nack_pend_q;
	logic                            scl_s1_q, scl_s2_q, scl_p_q;
	logic                            sda_s1_q, sda_s2_q, sda_p_q;
	logic                            scl_rise, scl_fall, bus_start, bus_stop;
	logic                            enabled;
	logic                            tx_pop;
	logic                            sda_d;
	logic                            fifo_valid;
	logic [ite_pkg::DATA_W-1:0]      fifo_data;
	logic [ite_pkg::BRW_W-1:0]       div_q;
	logic [ite_pkg::BCNT_W-1:0]      bytes_q;

	// first byte of a 10-bit address aimed at us
	function automatic logic ten_first(input logic [7:0] b, input logic [9:0] oa);
		ten_first = (b[7:3] == ite_pkg::TEN_PREFIX) && (b[2:1] == oa[9:8]); // see RL24
	endfunction

	// open-drain pins only ever pull low
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign enabled = (mode_select_field == ite_pkg::MODE_I2C) && sync_mode_bit
	                 && !master_select_bit && !software_reset_bit; // see RL1 see RL18

	// two-flop synchronisers, then a third stage for edge detection
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_p_q  <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_p_q  <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_p_q  <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_p_q  <= sda_s2_q;
		end
	end

	assign scl_rise  = scl_s2_q && !scl_p_q;
	assign scl_fall  = !scl_s2_q && scl_p_q;
	assign bus_start = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
	assign bus_stop  = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;

	// buffer to shifter moves: stalled-and-now-ready, or ack seen with data waiting
	assign tx_pop = enabled && fifo_valid && ((st_q == ite_pkg::ITE_WAIT_TX)
	                || (st_q == ite_pkg::ITE_TX_ACK && scl_fall && !ack_low_q));

	ite_fifo #(
		.WIDTH (ite_pkg::DATA_W),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (software_reset_bit),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (transmit_buffer),
		.out_valid (fifo_valid),
		.out_ready (tx_pop),
		.out_data  (fifo_data)
	);

	// bus busy watches the wire regardless of our own mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_busy_flag <= 1'b0;
		end else if (bus_start) begin
			bus_busy_flag <= 1'b1; // see RL23
		end else if (bus_stop) begin
			bus_busy_flag <= 1'b0; // see RL23
		end
	end

	// byte-level state machine; in tx_ack, ack_low_q holds the master's nack
	always_ff @(posedge sys_clk) begin
		if (rst || !enabled) begin
			st_q                   <= ite_pkg::ITE_IDLE; // see RL22
			next_q                 <= ite_pkg::ITE_IDLE;
			cnt_q                  <= '0;
			sr_q                   <= '0;
			ack_low_q              <= 1'b0;
			wait_addr_q            <= 1'b0;
			second_q               <= 1'b0;
			ten_ok_q               <= 1'b0;
			active_q               <= 1'b0;
			set_start_q            <= 1'b0;
			set_rx_q               <= 1'b0;
			nack_used_q            <= 1'b0;
			transfer_direction_bit <= 1'b0; // see RL2
			if (rst) begin
				receive_buffer <= '0;
			end
		end else begin
			set_start_q <= 1'b0;
			set_rx_q    <= 1'b0;
			nack_used_q <= 1'b0;
			if (bus_stop) begin
				st_q     <= ite_pkg::ITE_IDLE; // see RL10 see RL15
				active_q <= 1'b0;
				ten_ok_q <= 1'b0;
			end else if (bus_start) begin
				st_q     <= ite_pkg::ITE_ADDR; // see RL5 see RL10 see RL15
				cnt_q    <= '0;
				second_q <= 1'b0;
			end else begin
				case (st_q)
					ite_pkg::ITE_ADDR: begin
						if (scl_rise && cnt_q != ite_pkg::BIT_DONE) begin
							sr_q  <= {sr_q[6:0], sda_s2_q};
							cnt_q <= cnt_q + 1'b1;
						end else if (scl_fall && cnt_q == ite_pkg::BIT_DONE) begin
							cnt_q     <= '0;
							ack_low_q <= 1'b1;
							if (second_q) begin
								if (sr_q == own_address_reg0[7:0]) begin
									ten_ok_q               <= 1'b1;
									active_q               <= 1'b1;
									set_start_q            <= 1'b1; // see RL16
									transfer_direction_bit <= 1'b0;
									st_q                   <= ite_pkg::ITE_ACK;
									next_q                 <= ite_pkg::ITE_RX;
								end else begin
									st_q <= ite_pkg::ITE_IGNORE; // see RL25
								end
							end else if (general_call_enable && sr_q == ite_pkg::GEN_CALL_ADDR) begin
								active_q               <= 1'b1; // see RL4
								set_start_q            <= 1'b1;
								transfer_direction_bit <= 1'b0;
								st_q                   <= ite_pkg::ITE_ACK;
								next_q                 <= ite_pkg::ITE_RX;
							end else if (!own_address_width_bit && sr_q[7:1] == own_address_reg0[6:0]) begin
								active_q               <= 1'b1; // see RL3 see RL5
								set_start_q            <= 1'b1;
								transfer_direction_bit <= sr_q[0]; // see RL6 see RL7 see RL11
								st_q                   <= sr_q[0] ? ite_pkg::ITE_WAIT_TX : ite_pkg::ITE_ACK;
								next_q                 <= ite_pkg::ITE_RX;
								wait_addr_q            <= 1'b1;
							end else if (own_address_width_bit && ten_first(sr_q, own_address_reg0)) begin
								if (!sr_q[0]) begin
									second_q <= 1'b1; // see RL3
									st_q     <= ite_pkg::ITE_ACK;
									next_q   <= ite_pkg::ITE_ADDR;
								end else if (ten_ok_q) begin
									set_start_q            <= 1'b1; // see RL17
									transfer_direction_bit <= 1'b1;
									wait_addr_q            <= 1'b1;
									st_q                   <= ite_pkg::ITE_WAIT_TX;
								end else begin
									st_q <= ite_pkg::ITE_IGNORE;
								end
							end else begin
								st_q <= ite_pkg::ITE_IGNORE; // see RL25
							end
						end
					end
					ite_pkg::ITE_ACK: begin
						// ack/nack bit stands until the ninth clock falls
						if (scl_fall) begin
							st_q  <= next_q;
							cnt_q <= '0;
							if (next_q == ite_pkg::ITE_ADDR || next_q == ite_pkg::ITE_RX) begin
								second_q <= (next_q == ite_pkg::ITE_ADDR);
							end
						end
					end
					ite_pkg::ITE_RX: begin
						if (scl_rise && cnt_q != ite_pkg::BIT_DONE) begin
							sr_q  <= {sr_q[6:0], sda_s2_q};
							cnt_q <= cnt_q + 1'b1;
						end else if (scl_fall && cnt_q == ite_pkg::BIT_DONE) begin
							if (receive_flag && !nack_pend_q) begin
								st_q <= ite_pkg::ITE_RX_HOLD; // see RL12
							end else begin
								receive_buffer <= sr_q; // see RL11 see RL13
								set_rx_q       <= 1'b1; // see RL21
								ack_low_q      <= !nack_pend_q;
								nack_used_q    <= nack_pend_q;
								st_q           <= ite_pkg::ITE_ACK;
								next_q         <= ite_pkg::ITE_RX;
							end
						end
					end
					ite_pkg::ITE_RX_HOLD: begin
						// a nack request overrides the stall and drops the unread byte
						if (!receive_flag || nack_pend_q) begin
							receive_buffer <= sr_q; // see RL12 see RL14
							set_rx_q       <= 1'b1;
							ack_low_q      <= !nack_pend_q;
							nack_used_q    <= nack_pend_q;
							st_q           <= ite_pkg::ITE_ACK;
							next_q         <= ite_pkg::ITE_RX;
						end
					end
					ite_pkg::ITE_WAIT_TX: begin
						if (fifo_valid) begin
							sr_q        <= fifo_data; // see RL7 see RL9
							cnt_q       <= '0;
							wait_addr_q <= 1'b0;
							ack_low_q   <= 1'b1;
							st_q        <= wait_addr_q ? ite_pkg::ITE_ACK : ite_pkg::ITE_TX;
							next_q      <= ite_pkg::ITE_TX;
						end
					end
					ite_pkg::ITE_TX: begin
						// bits change only after the master's falling edge
						if (scl_fall) begin
							if (cnt_q == ite_pkg::BIT_LAST) begin
								st_q <= ite_pkg::ITE_TX_ACK;
							end else begin
								sr_q  <= {sr_q[6:0], 1'b0}; // see RL6
								cnt_q <= cnt_q + 1'b1;
							end
						end
					end
					ite_pkg::ITE_TX_ACK: begin
						if (scl_rise) begin
							ack_low_q <= sda_s2_q;
						end else if (scl_fall) begin
							cnt_q <= '0;
							if (ack_low_q) begin
								st_q <= ite_pkg::ITE_IGNORE; // see RL10
							end else if (fifo_valid) begin
								sr_q <= fifo_data; // see RL9
								st_q <= ite_pkg::ITE_TX;
							end else begin
								st_q <= ite_pkg::ITE_WAIT_TX; // see RL9
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// pin drives registered so they never glitch; a stretch outlasts a data change by a cycle
	assign sda_d = (st_q == ite_pkg::ITE_ACK && ack_low_q) || (st_q == ite_pkg::ITE_TX && !sr_q[7]);
	always_ff @(posedge sys_clk) begin
		if (rst || !enabled) begin
			sda_oe <= 1'b0; // see RL22
			scl_oe <= 1'b0;
		end else begin
			sda_oe <= sda_d;
			scl_oe <= (st_q == ite_pkg::ITE_RX_HOLD) || (st_q == ite_pkg::ITE_WAIT_TX)
			          || (scl_oe && sda_oe != sda_d); // see RL7 see RL12
		end
	end

	// pending nack request; a fresh request wins over the clear
	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit) begin
			nack_pend_q <= 1'b0;
		end else if (send_nack_bit) begin
			nack_pend_q <= 1'b1; // see RL13 see RL14
		end else if (nack_used_q) begin
			nack_pend_q <= 1'b0;
		end
	end

	// sticky event flags: set beats clear, software reset wipes them
	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit) begin
			start_detect_flag <= 1'b0; // see RL22
		end else if (set_start_q) begin
			start_detect_flag <= 1'b1; // see RL5
		end else if (start_clear) begin
			start_detect_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit) begin
			stop_detect_flag <= 1'b0;
		end else if (enabled && bus_stop && active_q) begin
			stop_detect_flag <= 1'b1; // see RL10 see RL15
		end else if (stop_clear) begin
			stop_detect_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit) begin
			transmit_request_flag <= 1'b0;
		end else if (tx_pop || st_q == ite_pkg::ITE_WAIT_TX) begin
			transmit_request_flag <= 1'b1; // see RL7 see RL8 see RL21
		end else if (tx_request_clear) begin
			transmit_request_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit) begin
			receive_flag <= 1'b0;
		end else if (set_rx_q) begin
			receive_flag <= 1'b1; // see RL11 see RL21
		end else if (receive_read) begin
			receive_flag <= 1'b0;
		end
	end

	// bit-rate divider on the only clock, live in controller mode
	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit || !master_select_bit || bit_rate_divider == '0) begin
			div_q         <= '0;
			bit_rate_tick <= 1'b0;
		end else if (div_q >= bit_rate_divider - 1'b1) begin
			div_q         <= '0; // see RL19
			bit_rate_tick <= 1'b1;
		end else begin
			div_q         <= div_q + 1'b1;
			bit_rate_tick <= 1'b0;
		end
	end

	// frame byte counter against the threshold when auto stop uses it
	always_ff @(posedge sys_clk) begin
		if (rst || software_reset_bit || bus_start) begin
			bytes_q        <= '0;
			byte_count_hit <= 1'b0;
		end else begin
			if (set_rx_q || tx_pop) begin
				bytes_q <= bytes_q + 1'b1;
			end
			byte_count_hit <= (auto_stop_field == ite_pkg::ASTP_BYTECNT)
			                  && (bytes_q == byte_count_threshold) && (byte_count_threshold != '0); // see RL20
		end
	end
endmodule // ite_top

// ==== test/ite_chk.sv ====
/*
 * ite_chk: pin and flag assertions for ite_top.
 * assumes: bound to ite_top; scl_i/sda_i are the resolved open-drain wires.
 */
`timescale 1ns/1ps
module ite_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic software_reset_bit,
	input wire logic receive_read,
	input wire logic receive_flag,
	input wire logic start_detect_flag,
	input wire logic stop_detect_flag,
	input wire logic transmit_request_flag,
	input wire logic bus_busy_flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// the engine may only ever pull a line low
	pins_od_a: assert property (!scl_o && !sda_o)
		else $error("pin output level not low");
	// a held software reset leaves both lines and all flags but bus busy released
	srst_pins_a: assert property (software_reset_bit [*2] |-> !scl_oe && !sda_oe)
		else $error("pin pulled under software reset");
	srst_flags_a: assert property (
		software_reset_bit [*2] |-> !(start_detect_flag || stop_detect_flag || transmit_request_flag || receive_flag))
		else $error("flag set under software reset");
	// raw pins lead the engine by the sync stages, hence the window
	busy_set_a: assert property (
		scl_i && $past(scl_i) && $fell(sda_i) && !software_reset_bit |-> ##[1:6] bus_busy_flag)
		else $error("busy not set after start");
	busy_clr_a: assert property (
		scl_i && $past(scl_i) && $rose(sda_i) && !software_reset_bit |-> ##[1:6] !bus_busy_flag)
		else $error("busy not cleared after stop");
	rx_hold_a: assert property (receive_flag && !receive_read && !software_reset_bit |=> receive_flag)
		else $error("receive flag lost without a read");
	// stretching only lengthens a low phase the controller began
	stretch_low_a: assert property ($rose(scl_oe) |-> !$past(scl_i) && !$past(scl_i, 2))
		else $error("clock pulled while high");
	sda_quiet_a: assert property ($changed(sda_oe) && !$past(software_reset_bit) |-> !scl_i)
		else $error("data moved while clock high");
endmodule // ite_chk

// ==== test/ite_bus_ctl.sv ====
/*
 * ite_bus_ctl: behavioural i2c bus controller on the far side of ite_top.
 * assumes: the bench resolves the open-drain wires; one task runs at a time.
 */
`timescale 1ns/1ps
module ite_bus_ctl #(
	parameter int Q = 10
) (
	input  wire logic sys_clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	// idle bus is released, pull-ups hold both lines high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic gap();
		repeat (Q) @(posedge sys_clk);
	endtask
	// one pulse; low phase well above the engine's sync delay, a held clock is waited out
	task automatic bit_io(input logic b, output logic r);
		int n;
		sda_low <= !b;
		gap();
		scl_low <= 1'b0;
		@(posedge sys_clk);
		for (n = 0; n < 30000 && scl !== 1'b1; n++) @(posedge sys_clk);
		gap();
		r = sda;
		scl_low <= 1'b1;
		gap();
	endtask
	// start from idle, or repeated start from a low clock
	task automatic start();
		sda_low <= 1'b0;
		gap();
		scl_low <= 1'b0;
		gap();
		sda_low <= 1'b1;
		gap();
		scl_low <= 1'b1;
		gap();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		gap();
		scl_low <= 1'b0;
		gap();
		sda_low <= 1'b0;
		gap();
	endtask
	// msb first, the ninth pulse carries the acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask
endmodule // ite_bus_ctl

// ==== test/tb_top.sv ====
/*
 * tb_top: self-checking bench for ite_top with a bus controller model.
 * assumes: ite_chk and ite_bus_ctl compiled before; 2-word tx buffer.
 */
`timescale 1ns/1ps
module tb_top;
	logic       sys_clk, rst, srst, mst, awid, gce, snack, txv, stc, spc, trc, hold_rx;
	logic       receive_read = 1'b0;
	logic [9:0] oa;
	logic [7:0] txb;
	logic [7:0] tx [5];
	logic [7:0] exp_q [$];
	int         fails, n_checks, n;
	wire        scl, sda, m_scl, m_sda, scl_o, sda_o, scl_oe, sda_oe, tx_ready;
	wire        sf, pf, tf, rf, bb, dir, tick, hit;
	wire  [7:0] rxb;

	// 25 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// open-drain wires: low while any party pulls
	assign scl = !(m_scl || scl_oe);
	assign sda = !(m_sda || sda_oe);

	ite_top #(.TX_DEPTH(2)) uut (
		.sys_clk(sys_clk), .rst(rst), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .software_reset_bit(srst),
		.mode_select_field(ite_pkg::MODE_I2C), .sync_mode_bit(1'b1), .master_select_bit(mst),
		.own_address_reg0(oa), .own_address_width_bit(awid), .general_call_enable(gce),
		.send_nack_bit(snack), .bit_rate_divider(16'h0008), .byte_count_threshold(8'h02),
		.auto_stop_field(ite_pkg::ASTP_BYTECNT), .transmit_buffer(txb), .tx_valid(txv),
		.tx_ready(tx_ready), .receive_buffer(rxb), .receive_read(receive_read), .start_clear(stc),
		.stop_clear(spc), .tx_request_clear(trc), .start_detect_flag(sf), .stop_detect_flag(pf),
		.transmit_request_flag(tf), .receive_flag(rf), .bus_busy_flag(bb),
		.transfer_direction_bit(dir), .bit_rate_tick(tick), .byte_count_hit(hit)
	);
	ite_bus_ctl bus (.sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] d, input logic ack);
		logic a;
		bus.wr_byte(d, a);
		chk("ack", 8'(a), 8'(ack));
	endtask
	task automatic rd(input logic [7:0] d, input logic nk);
		logic [7:0] r;
		bus.rd_byte(nk, r);
		chk("rd_data", r, d);
	endtask
	task automatic push(input logic [7:0] d);
		@(negedge sys_clk);
		txb = d;
		txv = 1'b1;
		@(negedge sys_clk);
		txv = 1'b0;
	endtask
	// setup is changed only with the software reset held
	task automatic cfg(input logic [9:0] a, input logic w, input logic g, input logic m);
		@(negedge sys_clk);
		srst = 1'b1;
		@(negedge sys_clk);
		{oa, awid, gce, mst} = {a, w, g, m};
		@(negedge sys_clk);
		srst = 1'b0;
	endtask
	task automatic clr();
		@(negedge sys_clk);
		{stc, spc, trc} = 3'h7;
		@(negedge sys_clk);
		{stc, spc, trc} = 3'h0;
	endtask

	// receive side: reads whenever allowed and compares with the oldest note
	always @(negedge sys_clk) begin
		if (rf === 1'b1 && !hold_rx && !receive_read) begin
			chk("rx_data", rxb, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
			receive_read <= 1'b1;
		end else
			receive_read <= 1'b0;
	end

	// watchdog: the whole run needs about 7k cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		fails++;
		test_done();
	end

	initial begin
		{rst, srst, mst, awid, gce, snack, txv, stc, spc, trc, hold_rx} = 11'h600;
		{oa, txb, fails, n_checks} = {10'h012, 8'h00, 32'h0, 32'h0};
		void'($urandom(32'h2472));
		for (int i = 0; i < 5; i++) tx[i] = 8'($urandom);
		cyc(4);
		rst = 1'b0;
		cyc(1);
		chk("idle", 8'({sf, pf, tf, rf, dir, scl_oe, sda_oe}), 8'h00);
		cfg(10'h012, 1'b0, 1'b0, 1'b1);
		for (n = 0; n < 100 && tick !== 1'b1; n++) @(negedge sys_clk);
		cyc(1);
		for (n = 1; n < 100 && tick !== 1'b1; n++) @(negedge sys_clk);
		chk("tick_gap", 8'(n), 8'h08);
		bus.start();
		wr(8'h24, 1'b0);
		bus.stop();
		$display("test master done");
		cfg(10'h012, 1'b0, 1'b0, 1'b0);
		bus.start();
		chk("busy", 8'(bb), 8'h01);
		wr(8'h24, 1'b1);
		chk("start", 8'(sf), 8'h01);
		chk("dir", 8'(dir), 8'h00);
		hold_rx = 1'b1;
		exp_q.push_back(tx[0]);
		exp_q.push_back(tx[1]);
		wr(tx[0], 1'b1);
		fork
			wr(tx[1], 1'b1);
			begin
				cyc(400);
				chk("rx_stall", 8'(scl_oe), 8'h01);
				hold_rx = 1'b0;
			end
		join
		chk("count", 8'(hit), 8'h01);
		bus.stop();
		cyc(8);
		chk("stop", 8'({pf, bb}), 8'h02);
		$display("test write done");
		fork
			begin
				bus.start();
				wr(8'h25, 1'b1);
			end
			begin
				cyc(330);
				chk("tx_stall", 8'(scl), 8'h00);
				chk("dir", 8'(dir), 8'h01);
				chk("tx_req", 8'(tf), 8'h01);
				push(tx[0]);
			end
		join
		for (int i = 1; i < 4; i++) begin
			@(negedge sys_clk);
			chk("tx_ready", 8'(tx_ready), 8'(i < 3));
			txb = tx[i];
			txv = 1'b1;
		end
		cyc(1);
		txv = 1'b0;
		clr();
		rd(tx[0], 1'b0);
		chk("tx_req", 8'(tf), 8'h01);
		rd(tx[1], 1'b0);
		rd(tx[2], 1'b1);
		bus.start();
		wr(8'h24, 1'b1);
		chk("dir", 8'(dir), 8'h00);
		bus.stop();
		cyc(8);
		chk("stop", 8'(pf), 8'h01);
		$display("test read done");
		for (int g = 0; g < 2; g++) begin
			cfg(10'h012, 1'b0, g[0], 1'b0);
			bus.start();
			wr(ite_pkg::GEN_CALL_ADDR, g[0]);
			bus.stop();
		end
		cfg(10'h012, 1'b0, 1'b0, 1'b0);
		bus.start();
		wr(8'h26, 1'b0);
		wr(8'h24, 1'b0);
		chk("start", 8'({sf, scl_oe}), 8'h00);
		bus.stop();
		$display("test address done");
		bus.start();
		wr(8'h24, 1'b1);
		@(negedge sys_clk);
		snack = 1'b1;
		@(negedge sys_clk);
		snack = 1'b0;
		exp_q.push_back(tx[3]);
		wr(tx[3], 1'b0);
		bus.stop();
		$display("test nack done");
		cfg(10'h2a5, 1'b1, 1'b0, 1'b0);
		bus.start();
		wr({ite_pkg::TEN_PREFIX, 2'h2, 1'b0}, 1'b1);
		wr(8'ha5, 1'b1);
		chk("start_dir", 8'({sf, dir}), 8'h02);
		clr();
		push(tx[4]);
		bus.start();
		wr({ite_pkg::TEN_PREFIX, 2'h2, 1'b1}, 1'b1);
		chk("start_dir", 8'({sf, dir}), 8'h03);
		rd(tx[4], 1'b1);
		bus.stop();
		$display("test ten_bit done");
		cfg(10'h012, 1'b0, 1'b0, 1'b0);
		bus.start();
		wr(8'h24, 1'b1);
		@(negedge sys_clk);
		srst = 1'b1;
		cyc(3);
		chk("srst", 8'({sf, pf, tf, rf, dir, scl_oe, sda_oe}), 8'h00);
		srst = 1'b0;
		bus.stop();
		$display("test soft_reset done");
		test_done();
	end
endmodule // tb_top

bind ite_top ite_chk chk_i (
	.sys_clk(sys_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .sda_o(sda_o),
	.scl_oe(scl_oe), .sda_oe(sda_oe), .software_reset_bit(software_reset_bit),
	.receive_read(receive_read), .receive_flag(receive_flag), .start_detect_flag(start_detect_flag),
	.stop_detect_flag(stop_detect_flag), .transmit_request_flag(transmit_request_flag),
	.bus_busy_flag(bus_busy_flag)
);
